// ==== bmde_unit.sv ====
// DMA bookkeeping and exception unit with Wishbone registers.
module bmde_unit
   import bmde_pkg::*;
#(
   parameter int RETRY_W = 8
)
(
   // Clock, reset and enable
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Command issue
   input  wire logic        cmdValid,
   input  wire logic [63:0] cmdWord,
   input  wire logic        cmdExecList,
   input  wire logic        cmdTerminate,
   input  wire logic        cmdBlock,
   input  wire logic        cmdRead,
   input  wire logic        cmdImmediate,
   input  wire logic [2:0]  cmdModeSel,
   input  wire logic [63:0] histWord,
   input  wire logic [31:0] listLength,
   input  wire logic [31:0] listAddr,
   input  wire logic [31:0] blockAddr,
   input  wire logic [31:0] blockBytes,
   // Stack reference
   input  wire logic        stackRef,
   input  wire logic [31:0] stackCurAddr,
   input  wire logic [31:0] stackEndAddr,
   input  wire logic [1:0]  stackPair,
   // Transfer moves and cycle results
   input  wire logic [2:0]  xferMove,
   input  wire logic        cycDone,
   input  wire logic        cycAddrPhase,
   input  wire logic [2:0]  cycSlaveStatus,
   input  wire logic        cycTimeout,
   input  wire logic        cycWaitTimeout,
   input  wire logic        cycParityErr,
   input  wire logic        arbTimeout,
   input  wire logic [31:0] curListAddr,
   // Status-history DMA write port
   output logic             histWrEn,
   output logic      [31:0] histWrAddr,
   output logic      [31:0] histWrData,
   input  wire logic        histWrReady,
   // Cycle control
   output logic             retryCycle,
   output logic             listActive,
   output logic             procCmdEnable,
   // Processor interrupt lines
   output logic             excIrq,
   input  wire logic        excAck,
   input  wire logic        srqIn,
   output logic             srqIrq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [31:0]        ptr_q   [NUM_PAIRS];
   logic [31:0]        cnt_q   [NUM_PAIRS];
   logic [SRC_W-1:0]   src_q;
   logic [SRC_W-1:0]   pendSrc_q;
   logic               pend_q;
   logic [7:0]         ctrl_q;
   logic [RETRY_W-1:0] retryLim_q;
   logic [RETRY_W-1:0] retryCnt_q;
   logic [63:0]        filt_q;
   logic               srqPrev_q;
   bmde_irq_t          irqSt_q;
   bmde_hist_t         hstSt_q;
   logic [SRC_W-1:0]   hstCode_q;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   function automatic logic [SRC_W-1:0] ssCode(input logic addrPh, input logic [2:0] ss);
      ssCode = (addrPh ? SRC_ADDR_BASE : SRC_DATA_BASE) + {3'h0, ss};
   endfunction : ssCode

   wire logic        busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic        busWr     = busReq & wb_we_i & wb_sel_i[0];
   wire logic        advEn     = ctrl_q[CTRL_ADV_BIT];
   wire logic [6:0]  ssEn      = filt_q[CMD_SS_HI:CMD_SS_LO];
   wire logic        ssNonZero = cycDone & (cycSlaveStatus != 3'h0);
   wire logic        isSs1     = cycDone & (cycSlaveStatus == 3'h1);
   wire logic        retryLeft = isSs1 & (retryCnt_q != retryLim_q);
   wire logic        ssExc     = ssNonZero & ~retryLeft & ssEn[cycSlaveStatus - 3'h1];
   wire logic        tmoEn     = cycAddrPhase ? filt_q[CMD_AK_EN] : filt_q[CMD_DK_EN];
   wire logic        tmoExc    = cycDone & cycTimeout & tmoEn;
   wire logic        wtExc     = cycDone & cycWaitTimeout & filt_q[CMD_WT_EN];
   wire logic        parExc    = cycDone & cycParityErr & ctrl_q[CTRL_PAR_EN];
   wire logic        arbExc    = arbTimeout & ctrl_q[CTRL_ARB_EN];
   wire logic        illegal   = cmdValid & ((~advEn & (cmdModeSel > MS_MAX_BASIC))
                                             | (cmdRead & cmdImmediate));
   wire logic [31:0] stackSum  = stackCurAddr + blockBytes;
   wire logic        stackLow  = stackRef & (stackSum > stackEndAddr);
   logic [2:0] ovfVec;
   wire logic        overflow  = |ovfVec;
   wire logic        anyEvent  = (ssNonZero & ~retryLeft) | (cycDone & (cycTimeout | cycWaitTimeout));

   // Exception priority: illegal, stack, overflow, arbitration timeout, then cycle results.
   wire logic [SRC_W-1:0] excCode =
      illegal  ? SRC_ILLEGAL :
      stackLow ? SRC_STACK :
      overflow ? SRC_OVERFLOW :
      arbExc   ? SRC_ARB_TMO :
      tmoExc   ? (cycAddrPhase ? SRC_ADDR_TMO : SRC_DATA_TMO) :
      wtExc    ? SRC_WT_TMO :
      parExc   ? SRC_PARITY :
      ssExc    ? ssCode(cycAddrPhase, cycSlaveStatus) : SRC_NONE;
   wire logic excNow = excCode != SRC_NONE;

   // History code; slave status and cycle timeouts are logged even when filtered.
   wire logic [SRC_W-1:0] logCode =
      excNow ? excCode :
      cycTimeout ? (cycAddrPhase ? SRC_ADDR_TMO : SRC_DATA_TMO) :
      cycWaitTimeout ? SRC_WT_TMO : ssCode(cycAddrPhase, cycSlaveStatus);

   wire logic startList = cmdValid & cmdExecList & ~listActive;
   wire logic endList   = listActive & ((cmdValid & cmdTerminate) | excNow | ctrl_q[CTRL_ABORT]);
   wire logic logEvent  = listActive & (anyEvent | excNow) & (hstSt_q == HST_IDLE);

   // ------------------------------------------------------------
   // Pointer and count pairs
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_PAIRS; i++)
   begin : g_pair
      wire logic load  = (i == PAIR_BLK) ? (cmdValid & cmdBlock) : startList;
      wire logic stk   = stackRef & (stackPair == 2'(i));
      wire logic histMv = (i == PAIR_HIST) & histWrEn & histWrReady;
      wire logic move  = xferMove[i] | histMv;
      wire logic [31:0] ldPtr = (i == PAIR_LIST) ? listAddr :
                                (i == PAIR_HIST) ? histWord[HIST_ADR_HI:HIST_ADR_LO] : blockAddr;
      wire logic [31:0] ldCnt = (i == PAIR_LIST) ? {listLength[29:0], 2'b00} :
                                (i == PAIR_HIST) ? {histWord[HIST_LEN_HI-2:HIST_LEN_LO], 2'b00} : blockBytes;
      assign ovfVec[i] = move & (cnt_q[i] == 32'h0);
      always_ff @(posedge sys_clk)
      begin
         if (!reset_n)
         begin
            ptr_q[i] <= 32'h0;
            cnt_q[i] <= 32'h0;
         end
         else if (clkEn)
         begin
            if (load)
            begin
               ptr_q[i] <= ldPtr;
               cnt_q[i] <= ldCnt;
            end
            else if (stk)
               ptr_q[i] <= stackCurAddr;
            else if (move && cnt_q[i] != 32'h0)
            begin
               ptr_q[i] <= ptr_q[i] + WORD_BYTES;
               cnt_q[i] <= cnt_q[i] - WORD_BYTES;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Filter, retry, list and control
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         filt_q     <= 64'h0;
         retryCnt_q <= '0;
         retryCycle <= 1'b0;
         listActive <= 1'b0;
         procCmdEnable <= 1'b1;
      end
      else if (clkEn)
      begin
         if (cmdValid)
            filt_q <= cmdWord;
         retryCycle <= retryLeft;
         if (retryLeft)
            retryCnt_q <= retryCnt_q + 1'b1;
         else if (cycDone)
            retryCnt_q <= '0;
         if (endList)
         begin
            listActive    <= 1'b0;
            procCmdEnable <= 1'b1;
         end
         else if (startList)
         begin
            listActive    <= 1'b1;
            procCmdEnable <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Status-history writer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         hstSt_q    <= HST_IDLE;
         hstCode_q  <= SRC_NONE;
         histWrEn   <= 1'b0;
         histWrAddr <= 32'h0;
         histWrData <= 32'h0;
      end
      else if (clkEn)
      begin
         case (hstSt_q)
            HST_IDLE:
            begin
               if (logEvent)
               begin
                  hstCode_q  <= logCode;
                  hstSt_q    <= HST_ADDR;
                  histWrEn   <= 1'b1;
                  histWrAddr <= ptr_q[PAIR_HIST];
                  histWrData <= curListAddr;
               end
            end
            HST_ADDR:
            begin
               if (histWrReady)
               begin
                  hstSt_q    <= HST_CODE;
                  histWrAddr <= ptr_q[PAIR_HIST] + WORD_BYTES;
                  histWrData <= {26'h0, hstCode_q};
               end
            end
            HST_CODE:
            begin
               if (histWrReady)
               begin
                  hstSt_q  <= HST_IDLE;
                  histWrEn <= 1'b0;
               end
            end
            default:
            begin
               hstSt_q  <= HST_IDLE;
               histWrEn <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Exception interrupt handshake
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         irqSt_q   <= IRQ_IDLE;
         excIrq    <= 1'b0;
         src_q     <= SRC_NONE;
         pend_q    <= 1'b0;
         pendSrc_q <= SRC_NONE;
      end
      else if (clkEn)
      begin
         if (excNow && !pend_q)
         begin
            pend_q    <= 1'b1;
            pendSrc_q <= excCode;
         end
         case (irqSt_q)
            IRQ_IDLE:
            begin
               if (pend_q && !excAck)
               begin
                  excIrq  <= 1'b1;
                  src_q   <= pendSrc_q;
                  pend_q  <= excNow;
                  irqSt_q <= IRQ_HIGH;
               end
            end
            IRQ_HIGH:
            begin
               if (excAck)
               begin
                  excIrq  <= 1'b0;
                  irqSt_q <= IRQ_WAIT;
               end
            end
            IRQ_WAIT:
            begin
               if (!excAck)
                  irqSt_q <= IRQ_IDLE;
            end
            default:
            begin
               irqSt_q <= IRQ_IDLE;
               excIrq  <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Service request and registers
   // ------------------------------------------------------------
   wire logic srqRise = srqIn & ~srqPrev_q;
   wire logic srqClr  = busWr & (wb_adr_i == REG_CONTROL) & wb_dat_i[CTRL_SRQ_CLR];

   wire logic [31:0] rdData =
      (wb_adr_i == REG_STATUS)   ? {21'h0, srqIrq, excIrq, listActive, 2'b00, src_q} :
      (wb_adr_i == REG_CONTROL)  ? {24'h0, ctrl_q} :
      (wb_adr_i == REG_RETRY)    ? 32'(retryLim_q) :
      (wb_adr_i == REG_LIST_PTR) ? ptr_q[PAIR_LIST] :
      (wb_adr_i == REG_LIST_CNT) ? cnt_q[PAIR_LIST] :
      (wb_adr_i == REG_HIST_PTR) ? ptr_q[PAIR_HIST] :
      (wb_adr_i == REG_HIST_CNT) ? cnt_q[PAIR_HIST] :
      (wb_adr_i == REG_BLK_PTR)  ? ptr_q[PAIR_BLK] :
      (wb_adr_i == REG_BLK_CNT)  ? cnt_q[PAIR_BLK] : 32'h0;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         srqPrev_q  <= 1'b0;
         srqIrq     <= 1'b0;
         ctrl_q     <= 8'h0;
         retryLim_q <= RETRY_W'(RETRY_RESET);
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0;
      end
      else if (clkEn)
      begin
         srqPrev_q <= srqIn;
         if (srqRise)
            srqIrq <= 1'b1;
         else if (srqClr)
            srqIrq <= 1'b0;
         wb_ack_o <= busReq;
         wb_dat_o <= busReq ? rdData : 32'h0;
         ctrl_q[CTRL_ABORT] <= 1'b0;
         if (busWr && wb_adr_i == REG_CONTROL)
            ctrl_q <= {wb_dat_i[7:2], 1'b0, wb_dat_i[CTRL_ADV_BIT]};
         if (busWr && wb_adr_i == REG_RETRY)
            retryLim_q <= wb_dat_i[RETRY_W-1:0];
      end
   end

endmodule : bmde_unit

// ==== bmde_pkg.sv ====
// Constants and types of the DMA and exception unit.
package bmde_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_STATUS    = 8'h00;
   localparam logic [7:0] REG_CONTROL   = 8'h04;
   localparam logic [7:0] REG_RETRY     = 8'h08;
   localparam logic [7:0] REG_LIST_PTR  = 8'h10;
   localparam logic [7:0] REG_LIST_CNT  = 8'h14;
   localparam logic [7:0] REG_HIST_PTR  = 8'h18;
   localparam logic [7:0] REG_HIST_CNT  = 8'h1c;
   localparam logic [7:0] REG_BLK_PTR   = 8'h20;
   localparam logic [7:0] REG_BLK_CNT   = 8'h24;

   // Control register bit positions.
   localparam int CTRL_ADV_BIT   = 0;
   localparam int CTRL_SRQ_CLR   = 1;
   localparam int CTRL_PAR_EN    = 2;
   localparam int CTRL_ARB_EN    = 3;
   localparam int CTRL_ABORT     = 4;

   // ------------------------------------------------------------
   // Command and history word fields
   // ------------------------------------------------------------
   localparam int CMD_SS_HI      = 53;
   localparam int CMD_SS_LO      = 47;
   localparam int CMD_WT_EN      = 46;
   localparam int CMD_AK_EN      = 45;
   localparam int CMD_DK_EN      = 44;
   localparam int HIST_LEN_HI    = 63;
   localparam int HIST_LEN_LO    = 32;
   localparam int HIST_ADR_HI    = 31;
   localparam int HIST_ADR_LO    = 0;
   localparam logic [2:0] MS_MAX_BASIC = 3'h3;

   // ------------------------------------------------------------
   // Exception source codes
   // ------------------------------------------------------------
   localparam int SRC_W = 6;
   localparam logic [SRC_W-1:0] SRC_NONE     = 6'h00;
   localparam logic [SRC_W-1:0] SRC_ADDR_BASE = 6'h00;
   localparam logic [SRC_W-1:0] SRC_ADDR_TMO = 6'h08;
   localparam logic [SRC_W-1:0] SRC_DATA_BASE = 6'h08;
   localparam logic [SRC_W-1:0] SRC_DATA_TMO = 6'h10;
   localparam logic [SRC_W-1:0] SRC_PARITY   = 6'h11;
   localparam logic [SRC_W-1:0] SRC_ARB_TMO  = 6'h12;
   localparam logic [SRC_W-1:0] SRC_WT_TMO   = 6'h13;
   localparam logic [SRC_W-1:0] SRC_OVERFLOW = 6'h14;
   localparam logic [SRC_W-1:0] SRC_STACK    = 6'h15;
   localparam logic [SRC_W-1:0] SRC_ILLEGAL  = 6'h16;

   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [7:0]  RETRY_RESET = 8'h00;

   // Pointer/count pair indices.
   localparam int NUM_PAIRS = 3;
   localparam int PAIR_LIST = 0;
   localparam int PAIR_HIST = 1;
   localparam int PAIR_BLK  = 2;

   typedef enum logic [1:0]
   {
      HST_IDLE = 2'b00,
      HST_ADDR = 2'b01,
      HST_CODE = 2'b11
   } bmde_hist_t;

   typedef enum logic [1:0]
   {
      IRQ_IDLE = 2'b00,
      IRQ_HIGH = 2'b01,
      IRQ_WAIT = 2'b11
   } bmde_irq_t;

endpackage : bmde_pkg

// ==== bmde_unit_checker.sv ====
// Port checks of the DMA and exception unit.
module bmde_unit_checker
   import bmde_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        reset_n,
   // Watched ports
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        cycDone,
   input wire logic [2:0]  cycSlaveStatus,
   input wire logic        srqIn,
   input wire logic [31:0] curListAddr,
   input wire logic        histWrEn,
   input wire logic [31:0] histWrAddr,
   input wire logic [31:0] histWrData,
   input wire logic        histWrReady,
   input wire logic        retryCycle,
   input wire logic        listActive,
   input wire logic        procCmdEnable,
   input wire logic        excIrq,
   input wire logic        excAck,
   input wire logic        srqIrq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Which word of a history record is on the port.
   logic        wordOdd_q;
   logic [31:0] firstAddr_q;
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         wordOdd_q <= 1'b0;
      else if (histWrEn && histWrReady)
         wordOdd_q <= !wordOdd_q;
      if (histWrEn && histWrReady && !wordOdd_q)
         firstAddr_q <= histWrAddr;
   end
   irq_hold_a: assert property (excIrq && !excAck |=> excIrq)
      else $error("irq dropped early");
   irq_drop_a: assert property (excIrq && excAck |=> !excIrq)
      else $error("irq held after ack");
   irq_rearm_a: assert property ($rose(excIrq) |-> !excAck && !$past(excAck))
      else $error("irq raised during ack");
   hist_first_a: assert property ($rose(histWrEn) |-> histWrData == curListAddr && !wordOdd_q)
      else $error("bad first history word");
   hist_code_a: assert property (histWrEn && wordOdd_q |-> histWrAddr == firstAddr_q + 32'h4
      && histWrData[31:6] == 26'h0 && histWrData[5:0] != 6'h0) else $error("bad history code");
   hist_mode_a: assert property ($rose(histWrEn) |-> $past(listActive))
      else $error("history outside list");
   retry_cause_a: assert property (retryCycle |-> $past(cycDone) && $past(cycSlaveStatus) == 3'h1)
      else $error("retry without status one");
   list_end_a: assert property ($fell(listActive) |-> ##[0:1] procCmdEnable)
      else $error("commands not enabled");
   srq_raise_a: assert property ($rose(srqIn) |-> ##[1:2] srqIrq)
      else $error("srq not raised");
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bad bus answer");
   irq_seen_c: cover property ($rose(excIrq));
   hist_seen_c: cover property (histWrEn && wordOdd_q && histWrReady);
   retry_seen_c: cover property (retryCycle);
   srq_seen_c: cover property ($rose(srqIrq));
endmodule : bmde_unit_checker

bind bmde_unit bmde_unit_checker i_chk (.*);

// ==== bmde_host_model.sv ====
// Host model: acknowledges interrupts and stores history words.
module bmde_host_model
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Interrupt and history ports
   input  wire logic        excIrq,
   output logic             excAck,
   input  wire logic        histWrEn,
   input  wire logic [31:0] histWrAddr,
   input  wire logic [31:0] histWrData,
   output logic             histWrReady,
   // Slow mode: stalled writes, late acknowledge
   input  wire logic        slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] memAddr [0:3];
   logic [31:0] memData [0:3];
   int          nWords = 0;
   int          age = 0;
   initial {excAck, histWrReady} = 2'b00;
   always @(posedge sys_clk)
   begin
      age = excIrq ? age + 1 : 0;
      excAck <= reset_n && excIrq && (excAck || age > (slow ? 3 : 0));
      histWrReady <= slow ? !histWrReady : 1'b1;
      if (reset_n && histWrEn && histWrReady && nWords < 4)
      begin
         memAddr[nWords] = histWrAddr;
         memData[nWords] = histWrData;
         nWords++;
      end
   end
endmodule : bmde_host_model

// ==== bmde_unit_test.sv ====
// Self-checking bench for the DMA and exception unit.
module bmde_unit_test
   import bmde_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] FULL = 32'hffff_ffff;
   logic        sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0, srqIn = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, cmdValid = 1'b0, cmdExecList = 1'b0;
   logic        cmdTerminate = 1'b0, cmdBlock = 1'b0, cmdRead = 1'b0, cmdImmediate = 1'b0, stackRef = 1'b0;
   logic        cycDone = 1'b0, cycAddrPhase = 1'b0, cycTimeout = 1'b0, cycWaitTimeout = 1'b0;
   logic        cycParityErr = 1'b0, arbTimeout = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [2:0]  cmdModeSel = 3'h0, xferMove = 3'h0, cycSlaveStatus = 3'h0;
   logic [1:0]  stackPair = 2'h2;
   logic [63:0] cmdWord = 64'h0, histWord = 64'h0;
   logic [31:0] wb_dat_i = 32'h0, listLength = 32'h0, listAddr = 32'h0, blockAddr = 32'h0, blockBytes = 32'h0;
   logic [31:0] stackCurAddr = 32'h100, stackEndAddr = 32'h180, curListAddr = 32'h0, rdata;
   logic [31:0] wb_dat_o, histWrAddr, histWrData;
   logic        wb_ack_o, histWrEn, histWrReady, retryCycle, listActive, procCmdEnable, excIrq, excAck, srqIrq;
   int          n_mismatch = 0, comparisons = 0;

   always #2 sys_clk = ~sys_clk;

   bmde_unit i_dut (.*, .clkEn(1'b1));
   bmde_host_model i_host (.*);

   // ------------------------------------------------------------
   // Bus cycles and comparisons
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rdata = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("wb ack", 32'h1, {31'h0, wb_ack_o});
   endtask : wb

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rdata & m);
   endtask : rdc

   // Flags are {cmdExecList, cmdTerminate, cmdBlock, cmdRead, cmdImmediate}.
   task automatic cmd(input logic [63:0] cw, input logic [4:0] k, input logic [2:0] ms);
      @(posedge sys_clk);
      cmdValid <= 1'b1;
      cmdWord <= cw;
      {cmdExecList, cmdTerminate, cmdBlock, cmdRead, cmdImmediate} <= k;
      cmdModeSel <= ms;
      @(posedge sys_clk);
      cmdValid <= 1'b0;
      {cmdExecList, cmdTerminate, cmdBlock, cmdRead, cmdImmediate} <= 5'h00;
   endtask : cmd

   // Faults are {cycTimeout, cycWaitTimeout, cycParityErr}.
   task automatic cyc(input logic ph, input logic [2:0] ss, input logic [2:0] f);
      @(posedge sys_clk);
      cycDone <= 1'b1;
      cycAddrPhase <= ph;
      cycSlaveStatus <= ss;
      {cycTimeout, cycWaitTimeout, cycParityErr} <= f;
      @(posedge sys_clk);
      cycDone <= 1'b0;
      {cycTimeout, cycWaitTimeout, cycParityErr} <= 3'h0;
   endtask : cyc

   task automatic pulse(input logic [2:0] mv, input logic sr, input logic arb);
      @(posedge sys_clk);
      xferMove <= mv;
      stackRef <= sr;
      arbTimeout <= arb;
      @(posedge sys_clk);
      xferMove <= 3'h0;
      stackRef <= 1'b0;
      arbTimeout <= 1'b0;
   endtask : pulse

   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (excIrq !== v && n < 30)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("excIrq", {31'h0, v}, {31'h0, excIrq});
   endtask : wait_irq

   task automatic exc(input logic [5:0] code);
      wait_irq(1'b1);
      rdc(REG_STATUS, 32'h3f, {26'h0, code}, "source");
      wait_irq(1'b0);
      repeat (2) @(posedge sys_clk);
   endtask : exc

   // Ors {retryCycle, excIrq | histWrEn} over six cycles.
   task automatic watch(input logic [1:0] e, input string nm);
      logic [1:0] s;
      s = 2'b00;
      repeat (6)
      begin
         @(posedge sys_clk);
         s = s | {retryCycle, excIrq | histWrEn};
      end
      chk(nm, {30'h0, e}, {30'h0, s});
   endtask : watch

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rdc(REG_STATUS, FULL, 32'h0, "status");
      rdc(REG_RETRY, FULL, {24'h0, RETRY_RESET}, "retry");
      rdc(REG_LIST_PTR, FULL, 32'h0, "list ptr");
      wb(1'b1, REG_LIST_PTR, 32'h55);
      rdc(REG_LIST_PTR, FULL, 32'h0, "ro ptr");
      wb(1'b1, REG_RETRY, 32'h3);
      rdc(REG_RETRY, 32'hff, 32'h3, "retry rw");
      rdc(8'h3c, FULL, 32'h0, "unmapped");
      $display("test regs done");
   endtask : t_regs

   task automatic t_list();
      listAddr <= 32'h1000;
      listLength <= 32'h4;
      histWord <= {32'h8, 32'h2000};
      cmd(64'h0, 5'h10, 3'h0);
      rdc(REG_LIST_PTR, FULL, 32'h1000, "list ptr");
      rdc(REG_LIST_CNT, FULL, 32'h10, "list cnt");
      rdc(REG_HIST_PTR, FULL, 32'h2000, "hist ptr");
      rdc(REG_HIST_CNT, FULL, 32'h20, "hist cnt");
      chk("list run", 32'h1, {31'h0, listActive & ~procCmdEnable});
      pulse(3'h1, 1'b0, 1'b0);
      rdc(REG_LIST_PTR, FULL, 32'h1004, "list ptr inc");
      rdc(REG_LIST_CNT, FULL, 32'hc, "list cnt dec");
      cmd(64'h0, 5'h08, 3'h0);
      rdc(REG_STATUS, 32'h100, 32'h0, "list bit");
      chk("list end", 32'h1, {31'h0, procCmdEnable & ~listActive});
      slow <= 1'b1;
      curListAddr <= 32'h1008;
      cmd(64'h0, 5'h10, 3'h0);
      cmd(64'h1 << (CMD_SS_LO + 2), 5'h00, 3'h0);
      cyc(1'b0, 3'h3, 3'h0);
      exc(6'h0b);
      chk("log count", 32'h2, 32'(i_host.nWords));
      chk("log addr0", 32'h2000, i_host.memAddr[0]);
      chk("log data0", 32'h1008, i_host.memData[0]);
      chk("log addr1", 32'h2004, i_host.memAddr[1]);
      chk("log data1", 32'hb, i_host.memData[1]);
      rdc(REG_HIST_PTR, FULL, 32'h2008, "hist ptr inc");
      chk("list abort", 32'h1, {31'h0, procCmdEnable & ~listActive});
      slow <= 1'b0;
      $display("test list done");
   endtask : t_list

   task automatic t_codes();
      cmd(64'h0, 5'h00, 3'h0);
      cyc(1'b1, 3'h5, 3'h0);
      watch(2'b00, "filtered");
      for (int ph = 0; ph < 2; ph++)
         for (int ss = 2; ss < 8; ss++)
         begin
            cmd(64'h1 << (CMD_SS_LO + ss - 1), 5'h00, 3'h0);
            cyc(ph[0], ss[2:0], 3'h0);
            exc(6'(ss + (ph == 0 ? 8 : 0)));
         end
      cmd(64'h1 << CMD_AK_EN, 5'h00, 3'h0);
      cyc(1'b1, 3'h0, 3'h4);
      exc(6'h08);
      cmd(64'h1 << CMD_DK_EN, 5'h00, 3'h0);
      cyc(1'b0, 3'h0, 3'h4);
      exc(6'h10);
      cmd(64'h1 << CMD_WT_EN, 5'h00, 3'h0);
      cyc(1'b0, 3'h0, 3'h2);
      exc(6'h13);
      wb(1'b1, REG_CONTROL, 32'h4);
      cmd(64'h0, 5'h02, 3'h0);
      cyc(1'b0, 3'h0, 3'h1);
      exc(6'h11);
      wb(1'b1, REG_CONTROL, 32'h8);
      cyc(1'b0, 3'h0, 3'h1);
      watch(2'b00, "parity masked");
      pulse(3'h0, 1'b0, 1'b1);
      exc(6'h12);
      $display("test codes done");
   endtask : t_codes

   task automatic t_faults();
      wb(1'b1, REG_RETRY, 32'h2);
      cmd(64'h1 << CMD_SS_LO, 5'h00, 3'h0);
      repeat (2)
      begin
         cyc(1'b0, 3'h1, 3'h0);
         watch(2'b10, "retry");
      end
      cyc(1'b0, 3'h1, 3'h0);
      exc(6'h09);
      wb(1'b1, REG_CONTROL, 32'h0);
      cmd(64'h0, 5'h00, 3'h4);
      exc(6'h16);
      wb(1'b1, REG_CONTROL, 32'h1);
      cmd(64'h0, 5'h00, 3'h4);
      watch(2'b00, "advanced mode");
      cmd(64'h0, 5'h03, 3'h0);
      exc(6'h16);
      blockBytes <= 32'h40;
      pulse(3'h0, 1'b1, 1'b0);
      watch(2'b00, "stack fits");
      rdc(REG_BLK_PTR, FULL, 32'h100, "stack ptr");
      blockBytes <= 32'h100;
      pulse(3'h0, 1'b1, 1'b0);
      exc(6'h15);
      blockAddr <= 32'h3000;
      blockBytes <= 32'h8;
      cmd(64'h0, 5'h04, 3'h0);
      rdc(REG_BLK_PTR, FULL, 32'h3000, "blk ptr");
      rdc(REG_BLK_CNT, FULL, 32'h8, "blk cnt");
      repeat (2) pulse(3'h4, 1'b0, 1'b0);
      rdc(REG_BLK_CNT, FULL, 32'h0, "blk cnt zero");
      pulse(3'h4, 1'b0, 1'b0);
      exc(6'h14);
      $display("test faults done");
   endtask : t_faults

   task automatic t_srq();
      srqIn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdc(REG_STATUS, 32'h400, 32'h400, "srq bit");
      wb(1'b1, REG_CONTROL, 32'h2);
      srqIn <= 1'b0;
      rdc(REG_STATUS, 32'h400, 32'h0, "srq clear");
      $display("test srq done");
   endtask : t_srq

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_list();
      t_codes();
      t_faults();
      t_srq();
      report_and_stop();
   end
endmodule : bmde_unit_test
